// *** hdl/stepper_mode_and_step_decode.sv ***
// Mode sequencer, fault latch and resolution decoder of a stepper driver
`timescale 1ns/1ps
module stepper_mode_and_step_decode #(
  parameter int SLEEP_CYC = stepper_ctrl_pkg::SLEEP_ENTRY_CYC,
  parameter int WAKE_CYCLES = stepper_ctrl_pkg::WAKE_CYC,
  parameter int CLR_MIN = stepper_ctrl_pkg::RST_MIN_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Pins from the controller
  input wire logic i_sleep_request_bar,
  input wire logic i_step,
  input wire logic i_dir,
  input wire stepper_ctrl_pkg::level_t i_enable_lvl,
  input wire stepper_ctrl_pkg::level_t i_resolution_select0,
  input wire stepper_ctrl_pkg::level_t i_resolution_select1,
  // Analog side status
  input wire logic i_supply_low_lockout,
  input wire logic i_fault_event,
  input wire logic i_chop_trip,
  input wire logic [7:0] i_max_step_level,
  // Outputs
  output logic [1:0] o_mode,
  output stepper_ctrl_pkg::status_t o_status,
  output stepper_ctrl_pkg::resolution_t o_resolution,
  output logic [7:0] o_current_pct,
  output logic o_chop_at_full_scale,
  output logic o_slow_decay,
  output logic [stepper_ctrl_pkg::MSTEP_W-1:0] o_microstep,
  output logic o_fault_flag_bar_out,
  output logic o_fault_flag_bar_oe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] slp_sync;
    logic [1:0] stp_sync;
    logic [1:0] dir_sync;
    logic stp_prev;
    stepper_ctrl_pkg::level_t en_a, en_b, en_c, en;
    stepper_ctrl_pkg::level_t s0_a, s0_b, s0_c, s0;
    stepper_ctrl_pkg::level_t s1_a, s1_b, s1_c, s1;
    stepper_ctrl_pkg::mode_t mode;
    logic [stepper_ctrl_pkg::CNT_W-1:0] low_cnt;
    logic [stepper_ctrl_pkg::CNT_W-1:0] wake_cnt;
    logic fault_latched;
    logic slow_decay;
    logic [stepper_ctrl_pkg::MSTEP_W-1:0] mstep;
    stepper_ctrl_pkg::resolution_t res;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Step increment for the microstep counter at each resolution
  function automatic logic [stepper_ctrl_pkg::MSTEP_W-1:0] step_inc(
    input stepper_ctrl_pkg::resolution_t r);
    case (r)
      stepper_ctrl_pkg::RES_FULL, stepper_ctrl_pkg::RES_FULL71:
        step_inc = 9'h080;
      stepper_ctrl_pkg::RES_HALF_NC, stepper_ctrl_pkg::RES_HALF:
        step_inc = 9'h040;
      stepper_ctrl_pkg::RES_QUARTER: step_inc = 9'h020;
      stepper_ctrl_pkg::RES_EIGHTH: step_inc = 9'h010;
      stepper_ctrl_pkg::RES_16: step_inc = 9'h008;
      stepper_ctrl_pkg::RES_32: step_inc = 9'h004;
      stepper_ctrl_pkg::RES_64: step_inc = 9'h002;
      default: step_inc = 9'h001;
    endcase
  endfunction

  function automatic stepper_ctrl_pkg::resolution_t decode_res(
    input stepper_ctrl_pkg::level_t lvl0,
    input stepper_ctrl_pkg::level_t lvl1);
    logic [3:0] k;
    k = {lvl0, lvl1};
    case (k)
      {stepper_ctrl_pkg::LVL_LOW, stepper_ctrl_pkg::LVL_LOW}:
        decode_res = stepper_ctrl_pkg::RES_FULL;
      {stepper_ctrl_pkg::LVL_LOW, stepper_ctrl_pkg::LVL_RES}:
        decode_res = stepper_ctrl_pkg::RES_FULL71;
      {stepper_ctrl_pkg::LVL_HIGH, stepper_ctrl_pkg::LVL_LOW}:
        decode_res = stepper_ctrl_pkg::RES_HALF_NC;
      {stepper_ctrl_pkg::LVL_FLOAT, stepper_ctrl_pkg::LVL_LOW}:
        decode_res = stepper_ctrl_pkg::RES_HALF;
      {stepper_ctrl_pkg::LVL_LOW, stepper_ctrl_pkg::LVL_HIGH}:
        decode_res = stepper_ctrl_pkg::RES_QUARTER;
      {stepper_ctrl_pkg::LVL_HIGH, stepper_ctrl_pkg::LVL_HIGH}:
        decode_res = stepper_ctrl_pkg::RES_EIGHTH;
      {stepper_ctrl_pkg::LVL_FLOAT, stepper_ctrl_pkg::LVL_HIGH}:
        decode_res = stepper_ctrl_pkg::RES_16;
      {stepper_ctrl_pkg::LVL_LOW, stepper_ctrl_pkg::LVL_FLOAT}:
        decode_res = stepper_ctrl_pkg::RES_32;
      {stepper_ctrl_pkg::LVL_FLOAT, stepper_ctrl_pkg::LVL_RES}:
        decode_res = stepper_ctrl_pkg::RES_64;
      {stepper_ctrl_pkg::LVL_FLOAT, stepper_ctrl_pkg::LVL_FLOAT}:
        decode_res = stepper_ctrl_pkg::RES_128;
      {stepper_ctrl_pkg::LVL_HIGH, stepper_ctrl_pkg::LVL_FLOAT}:
        decode_res = stepper_ctrl_pkg::RES_256;
      // Unlisted pairs fall back to the finest mode
      default: decode_res = stepper_ctrl_pkg::RES_256;
    endcase
  endfunction

  logic slp_hi;
  logic stp_rise;
  logic en_low;
  logic pulse_end;
  logic clr_pulse;

  assign slp_hi = st_r.slp_sync[1];
  assign stp_rise = st_r.stp_sync[1] & ~st_r.stp_prev;
  assign en_low = (st_r.en == stepper_ctrl_pkg::LVL_LOW);
  // Sleep request returning high after a low of clearing width
  assign pulse_end = slp_hi & (st_r.low_cnt != '0);
  assign clr_pulse = pulse_end &
    (st_r.low_cnt >= stepper_ctrl_pkg::CNT_W'(CLR_MIN));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.slp_sync = {st_r.slp_sync[0], i_sleep_request_bar};
    st_nxt.stp_sync = {st_r.stp_sync[0], i_step};
    st_nxt.dir_sync = {st_r.dir_sync[0], i_dir};
    st_nxt.stp_prev = st_r.stp_sync[1];
    // Level codes take two flops and a third for comparison, then a register holds the stable code
    st_nxt.en_a = i_enable_lvl;
    st_nxt.en_b = st_r.en_a;
    st_nxt.en_c = st_r.en_b;
    st_nxt.s0_a = i_resolution_select0;
    st_nxt.s0_b = st_r.s0_a;
    st_nxt.s0_c = st_r.s0_b;
    st_nxt.s1_a = i_resolution_select1;
    st_nxt.s1_b = st_r.s1_a;
    st_nxt.s1_c = st_r.s1_b;
    // Only synchronised copies are compared, never the metastable flop
    if (st_r.en_c == st_r.en_b) begin
      st_nxt.en = st_r.en_c;
    end
    if ((st_r.s0_c == st_r.s0_b) && (st_r.s1_c == st_r.s1_b)) begin
      st_nxt.s0 = st_r.s0_c;
      st_nxt.s1 = st_r.s1_c;
    end
    st_nxt.res = decode_res(st_r.s0, st_r.s1);

    // Length of the current low phase of the sleep request
    if (!slp_hi) begin
      if (st_r.low_cnt != {stepper_ctrl_pkg::CNT_W{1'b1}}) begin
        st_nxt.low_cnt = st_r.low_cnt + 1'b1;
      end
    end else begin
      st_nxt.low_cnt = '0;
    end

    // Fault latch; a new event wins over a clearing pulse
    if (i_fault_event && st_r.mode != stepper_ctrl_pkg::MODE_SLEEP) begin
      st_nxt.fault_latched = 1'b1;
    end else if (clr_pulse) begin
      st_nxt.fault_latched = 1'b0;
    end else if (st_r.en != stepper_ctrl_pkg::LVL_FLOAT &&
                 !i_fault_event) begin
      // Retry mode releases as soon as the condition is gone
      st_nxt.fault_latched = 1'b0;
    end

    case (st_r.mode)
      stepper_ctrl_pkg::MODE_SLEEP: begin
        st_nxt.fault_latched = 1'b0;
        if (slp_hi) begin
          st_nxt.mode = stepper_ctrl_pkg::MODE_WAKING;
          st_nxt.wake_cnt = '0;
        end
      end
      stepper_ctrl_pkg::MODE_WAKING: begin
        st_nxt.wake_cnt = st_r.wake_cnt + 1'b1;
        if (st_r.low_cnt >= stepper_ctrl_pkg::CNT_W'(SLEEP_CYC)) begin
          st_nxt.mode = stepper_ctrl_pkg::MODE_SLEEP;
        end else if (slp_hi && st_r.wake_cnt >=
                     stepper_ctrl_pkg::CNT_W'(WAKE_CYCLES - 1)) begin
          st_nxt.mode = stepper_ctrl_pkg::MODE_DISABLED;
        end
      end
      default: begin
        // Sleep only once the low has outlasted the entry delay
        if (st_r.low_cnt >= stepper_ctrl_pkg::CNT_W'(SLEEP_CYC)) begin
          st_nxt.mode = stepper_ctrl_pkg::MODE_SLEEP;
        end else if (st_nxt.fault_latched &&
                     st_r.en == stepper_ctrl_pkg::LVL_FLOAT) begin
          st_nxt.mode = stepper_ctrl_pkg::MODE_FAULTED;
        end else if (en_low || i_supply_low_lockout ||
                     st_nxt.fault_latched) begin
          st_nxt.mode = stepper_ctrl_pkg::MODE_DISABLED;
        end else begin
          st_nxt.mode = stepper_ctrl_pkg::MODE_ACTIVE;
        end
      end
    endcase

    // Chopping: slow decay after trip, released on the next step
    if (i_chop_trip && st_r.mode == stepper_ctrl_pkg::MODE_ACTIVE) begin
      st_nxt.slow_decay = 1'b1;
    end else if (stp_rise) begin
      st_nxt.slow_decay = 1'b0;
    end
    if (st_r.mode == stepper_ctrl_pkg::MODE_SLEEP) begin
      st_nxt.mstep = '0;
    end else if (stp_rise &&
                 st_r.mode != stepper_ctrl_pkg::MODE_WAKING) begin
      // Indexer keeps counting while disabled so position survives
      if (st_r.dir_sync[1]) begin
        st_nxt.mstep = st_r.mstep + step_inc(st_r.res);
      end else begin
        st_nxt.mstep = st_r.mstep - step_inc(st_r.res);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_r <= '0;
      st_r.mode <= stepper_ctrl_pkg::MODE_SLEEP;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic asleep;
  logic pump_on;
  assign asleep = (st_r.mode == stepper_ctrl_pkg::MODE_SLEEP);
  // A clearing pulse shorter than the sleep entry delay never reaches sleep, so the pump stays as it was
  assign pump_on = ~asleep;

  always_comb begin
    o_status.bridge_on = (st_r.mode == stepper_ctrl_pkg::MODE_ACTIVE);
    o_status.bridge_hiz = ~o_status.bridge_on;
    o_status.charge_pump_on = pump_on;
    o_status.indexer_on = ~asleep & (st_r.mode !=
                          stepper_ctrl_pkg::MODE_WAKING);
    o_status.ready = ~asleep & (st_r.mode !=
                     stepper_ctrl_pkg::MODE_WAKING);
    o_mode = (st_r.mode == stepper_ctrl_pkg::MODE_ACTIVE) ? 2'h2 :
             asleep ? 2'h0 : 2'h1;
  end

  assign o_resolution = st_r.res;
  assign o_current_pct = (st_r.res == stepper_ctrl_pkg::RES_FULL71) ?
                         8'h47 : 8'h64;
  // Largest indexer step uses the full-scale current as trip point
  assign o_chop_at_full_scale = (i_max_step_level == 8'hFF);
  assign o_slow_decay = st_r.slow_decay;
  assign o_microstep = st_r.mstep;
  assign o_fault_flag_bar_out = 1'b0;
  assign o_fault_flag_bar_oe = st_r.fault_latched |
                               (i_supply_low_lockout & ~asleep);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_sleep_off: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    asleep |-> !o_status.bridge_on && !o_status.charge_pump_on)
    else $error("bridge or pump on in sleep");
  chk_sleep_delay: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    $rose(asleep) |->
    $past(st_r.low_cnt) >= stepper_ctrl_pkg::CNT_W'(SLEEP_CYC))
    else $error("sleep entered early");
  chk_wake_auto: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    asleep && slp_hi |=> st_r.mode == stepper_ctrl_pkg::MODE_WAKING)
    else $error("no wake on high request");
  chk_en_low_hiz: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    st_r.mode == stepper_ctrl_pkg::MODE_DISABLED |-> o_status.bridge_hiz &&
    o_status.charge_pump_on)
    else $error("disabled mode drives bridge");
  chk_fault_clear: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    clr_pulse && !i_fault_event && !asleep |=> !st_r.fault_latched)
    else $error("clearing pulse ignored");
  chk_short_keep: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    pulse_end && !clr_pulse && st_r.fault_latched &&
    st_r.en == stepper_ctrl_pkg::LVL_FLOAT |=> st_r.fault_latched)
    else $error("short pulse cleared fault");
  chk_latched_off: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    st_r.mode == stepper_ctrl_pkg::MODE_FAULTED |-> !o_status.bridge_on &&
    o_fault_flag_bar_oe)
    else $error("latched fault not holding");
  chk_res_full71: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    st_r.res == stepper_ctrl_pkg::RES_FULL71 |-> o_current_pct == 8'h47)
    else $error("full step current wrong");
  cov_wake: cover property (@(posedge i_mclk)
    st_r.mode == stepper_ctrl_pkg::MODE_WAKING ##1
    st_r.mode == stepper_ctrl_pkg::MODE_DISABLED);
  cov_clear: cover property (@(posedge i_mclk) clr_pulse);
  cov_step: cover property (@(posedge i_mclk)
    stp_rise && st_r.mode == stepper_ctrl_pkg::MODE_ACTIVE);

endmodule // stepper_mode_and_step_decode

// *** hdl/stepper_ctrl_pkg.sv ***
// Shared constants and types for the stepper mode and step decode block
package stepper_ctrl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int SLEEP_ENTRY_DELAY_US = 120;
  localparam int WAKE_DELAY_US = 1000;
  localparam int RST_PULSE_MIN_US = 20;
  localparam int RST_PULSE_MAX_US = 40;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_DELAY_US * CLK_MHZ;
  localparam int WAKE_CYC = WAKE_DELAY_US * CLK_MHZ;
  localparam int RST_MIN_CYC = RST_PULSE_MIN_US * CLK_MHZ + 1;
  localparam int RST_MAX_CYC = RST_PULSE_MAX_US * CLK_MHZ;
  localparam int CNT_W = 20;
  localparam int MSTEP_W = 9;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Resolved pin level: low, high, floating, resistor to ground
  typedef enum logic [1:0] {LVL_LOW, LVL_HIGH, LVL_FLOAT, LVL_RES} level_t;

  typedef enum logic [3:0] {
    RES_FULL, RES_FULL71, RES_HALF_NC, RES_HALF, RES_QUARTER,
    RES_EIGHTH, RES_16, RES_32, RES_64, RES_128, RES_256
  } resolution_t;

  typedef enum logic [2:0] {
    MODE_SLEEP, MODE_WAKING, MODE_DISABLED, MODE_ACTIVE, MODE_FAULTED
  } mode_t;

  typedef struct packed {
    logic bridge_on;
    logic bridge_hiz;
    logic charge_pump_on;
    logic indexer_on;
    logic ready;
  } status_t;

endpackage

// *** tb/motion_ctrl_model.sv ***
// Motion controller model driving the step and direction pins
`timescale 1ns/1ps
module motion_ctrl_model (
  // Clock
  input wire logic i_mclk,
  // Requests from the bench
  input wire logic i_go,
  input wire logic i_dir_req,
  input wire logic [7:0] i_pulses,
  input wire logic [3:0] i_half,
  // Step and direction pins toward the driver, busy flag to the bench
  output logic o_step,
  output logic o_dir,
  output logic o_busy
);
  initial begin
    o_step = 1'b0;
    o_dir = 1'b0;
    o_busy = 1'b0;
  end
  // Equal high and low halves keep the step rate steady
  always begin
    @(posedge i_mclk);
    if (i_go) begin
      o_busy = 1'b1;
      @(negedge i_mclk);
      o_dir = i_dir_req;
      repeat (i_half) @(negedge i_mclk);
      for (int n = 0; n < i_pulses; n++) begin
        o_step = 1'b1;
        repeat (i_half) @(negedge i_mclk);
        o_step = 1'b0;
        repeat (i_half) @(negedge i_mclk);
      end
      o_busy = 1'b0;
    end
  end
endmodule // motion_ctrl_model

// *** tb/tb_top.sv ***
// Self-checking bench for the stepper mode and step decode block
`timescale 1ns/1ps
`define CHECK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin \
  fails++; $display("[ERR] t=%0t got %0h exp %0h", $time, act, exp); end end
module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int SLP = 50;
  localparam int WAK = 20;
  localparam int CLR = 10;
  logic mclk, rst, slp_bar, step, dir, sup, fev, chop, chop_fs, slow;
  logic go, dirq, busy, foe, fout;
  stepper_ctrl_pkg::level_t en, sel0, sel1;
  stepper_ctrl_pkg::status_t st;
  stepper_ctrl_pkg::resolution_t res;
  logic [1:0] mode;
  logic [7:0] maxl, pct, npul;
  logic [8:0] ms, ms0;
  logic [3:0] code, r;
  logic [3:0] code_of [11] = '{4'h0, 4'h3, 4'h4, 4'h8, 4'h1, 4'h5, 4'h9,
    4'h2, 4'hB, 4'hA, 4'h6};
  integer seed;
  int fails, cmp_count;

  stepper_mode_and_step_decode #(
    .SLEEP_CYC(SLP), .WAKE_CYCLES(WAK), .CLR_MIN(CLR)
  ) i_dut (
    .i_mclk(mclk), .i_rst(rst), .i_sleep_request_bar(slp_bar),
    .i_step(step), .i_dir(dir), .i_enable_lvl(en),
    .i_resolution_select0(sel0), .i_resolution_select1(sel1),
    .i_supply_low_lockout(sup), .i_fault_event(fev), .i_chop_trip(chop),
    .i_max_step_level(maxl), .o_mode(mode), .o_status(st),
    .o_resolution(res), .o_current_pct(pct),
    .o_chop_at_full_scale(chop_fs), .o_slow_decay(slow),
    .o_microstep(ms), .o_fault_flag_bar_out(fout),
    .o_fault_flag_bar_oe(foe)
  );
  motion_ctrl_model i_ctrl (
    .i_mclk(mclk), .i_go(go), .i_dir_req(dirq), .i_pulses(npul),
    .i_half(4'h4), .o_step(step), .o_dir(dir), .o_busy(busy)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Select pair {select0, select1} to resolution; unlisted pairs go finest
  function automatic logic [3:0] exp_res(input logic [3:0] c);
    for (int i = 0; i < 11; i++) begin
      if (code_of[i] == c) return 4'(i);
    end
    return 4'hA;
  endfunction

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wait_mode(input logic [1:0] m, input int bound);
    int t;
    t = 0;
    while (mode !== m && t < bound) begin
      @(negedge mclk);
      t++;
    end
    cmp_count++;
    if (mode !== m) begin
      fails++;
      $display("[ERR] t=%0t got %0h exp %0h", $time, mode, m);
      report_and_stop();
    end
  endtask

  task automatic move(input logic d, input logic [7:0] n);
    int t;
    dirq = d;
    npul = n;
    go = 1'b1;
    @(negedge mclk);
    go = 1'b0;
    t = 0;
    while (busy && t < 3000) begin
      @(negedge mclk);
      t++;
    end
    if (busy) begin
      fails++;
      report_and_stop();
    end
    repeat (5) @(negedge mclk);
  endtask

  task automatic set_sel(input logic [3:0] c);
    sel0 = stepper_ctrl_pkg::level_t'(c[3:2]);
    sel1 = stepper_ctrl_pkg::level_t'(c[1:0]);
    repeat (6) @(negedge mclk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hDE40;
    fails = 0;
    cmp_count = 0;
    rst = 1'b1;
    slp_bar = 1'b0;
    en = stepper_ctrl_pkg::LVL_HIGH;
    sel0 = stepper_ctrl_pkg::LVL_LOW;
    sel1 = stepper_ctrl_pkg::LVL_LOW;
    {sup, fev, chop, go, dirq} = 5'h00;
    maxl = 8'h00;
    npul = 8'h00;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    `CHECK(mode, 2'h0)
    `CHECK(st, 5'h08)
    slp_bar = 1'b1;
    wait_mode(2'h2, WAK + 20);
    `CHECK(st, 5'h17)
    for (int k = 0; k < 28; k++) begin
      code = (k < 16) ? 4'(k) : 4'($random(seed));
      set_sel(code);
      `CHECK(res, exp_res(code))
      if (exp_res(code) < 4'h2) `CHECK(pct, code[0] ? 8'h47 : 8'h64)
    end
    // Forward then reverse moves at half to 1/128 step must return the indexer to its start
    for (int k = 0; k < 6; k++) begin
      r = 4'h3 + 4'($unsigned($random(seed)) % 7);
      set_sel(code_of[r]);
      ms0 = ms;
      npul = 8'h01 + 8'($unsigned($random(seed)) % 8);
      move(1'b1, npul);
      `CHECK(ms, 9'(ms0 + npul * (9'h080 >> (r - 4'h2))))
      move(1'b0, npul);
      `CHECK(ms, ms0)
    end
    en = stepper_ctrl_pkg::LVL_LOW;
    wait_mode(2'h1, 10);
    `CHECK({st.bridge_on, st.bridge_hiz}, 2'b01)
    `CHECK({st.charge_pump_on, st.indexer_on}, 2'b11)
    en = stepper_ctrl_pkg::LVL_HIGH;
    wait_mode(2'h2, 10);
    sup = 1'b1;
    repeat (6) @(negedge mclk);
    `CHECK(mode === 2'h2, 1'b0)
    sup = 1'b0;
    wait_mode(2'h2, WAK + 20);
    for (int k = 0; k < 6; k++) begin
      maxl = (k < 2) ? 8'hFF - 8'(k) : 8'($random(seed));
      @(negedge mclk);
      `CHECK(chop_fs, maxl == 8'hFF)
    end
    chop = 1'b1;
    @(negedge mclk);
    chop = 1'b0;
    repeat (3) @(negedge mclk);
    `CHECK(slow, 1'b1)
    move(1'b1, 8'h01);
    `CHECK(slow, 1'b0)
    en = stepper_ctrl_pkg::LVL_FLOAT;
    for (int w = CLR + 5; w < SLP; w += SLP - CLR - 13) begin
      fev = 1'b1;
      repeat (4) @(negedge mclk);
      `CHECK(foe, 1'b1)
      fev = 1'b0;
      repeat (6) @(negedge mclk);
      `CHECK({foe, st.bridge_on}, 2'b10)
      // A low shorter than the clearing width must leave the fault latched
      slp_bar = 1'b0;
      repeat (CLR - 2) @(negedge mclk);
      slp_bar = 1'b1;
      repeat (6) @(negedge mclk);
      `CHECK(foe, 1'b1)
      slp_bar = 1'b0;
      repeat (w) @(negedge mclk);
      slp_bar = 1'b1;
      repeat (6) @(negedge mclk);
      `CHECK({foe, fout}, 2'b00)
      `CHECK(st.charge_pump_on, 1'b1)
      wait_mode(2'h2, 10);
    end
    en = stepper_ctrl_pkg::LVL_HIGH;
    fev = 1'b1;
    repeat (4) @(negedge mclk);
    `CHECK(foe, 1'b1)
    fev = 1'b0;
    repeat (6) @(negedge mclk);
    `CHECK(foe, 1'b0)
    slp_bar = 1'b0;
    repeat (SLP / 2) @(negedge mclk);
    `CHECK(mode === 2'h0, 1'b0)
    wait_mode(2'h0, SLP + 10);
    `CHECK({st.bridge_on, st.charge_pump_on}, 2'b00)
    @(negedge mclk);
    ms0 = ms;
    move(1'b1, 8'h02);
    `CHECK(ms, ms0)
    slp_bar = 1'b1;
    wait_mode(2'h2, WAK + 20);
    report_and_stop();
  end
endmodule // tb_top
